// ---- verilog/operand_addr_gen.sv ----
/*
  Operand-address generator and instruction-length decoder.
  Assumes bytes from the fetch stream arrive in program order and that the
  data memory answers pointer reads with mem_valid_i.
*/
// Overview of operation
// - inherent instructions are one byte, opcode carries everything.
// - immediate is opcode plus one operand value byte.
// - short direct takes one address byte, reach 00 to FF.
// - long direct takes a 16-bit address from two following bytes.
// - short direct and short indirect stay in page zero 0000h to 00FFh.
// - read-modify-write instructions allow only short forms.
// - indexed address is unsigned sum of chosen index and offset.
// - no-offset indexed uses index alone, no extra byte.
// - short indexed adds a byte offset, range 00 to 1FE.
// - long indexed adds a two-byte offset, full 64 Kbyte.
// - indirect reads pointer address byte, then fetches from memory.
// - short indirect fetches one page-zero byte as address.
// - long indirect forms fetch a two-byte pointer at a byte address.
// - indirect indexed adds index to fetched pointer, unsigned.
// - short indirect indexed gives range 00 to 1FE.
// - set-mask raises mask to 3, clear-mask lowers it to 0.
// - relative modes add a signed 8-bit displacement to PC.
// - prefix 92 turns direct into indirect, short and long X indexed into indirect.
// - prefix 90 selects the second index register.
// - an undefined code raises a reset.
`timescale 1ns/1ps
module operand_addr_gen (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic fetch_valid_i,
  input wire logic [7:0] fetch_byte_i,
  output logic fetch_ready_o,
  input wire logic [7:0] index_x_i,
  input wire logic [7:0] index_y_i,
  input wire logic [15:0] pc_i,
  output logic mem_rd_o,
  output logic [15:0] mem_addr_o,
  input wire logic mem_valid_i,
  input wire logic [7:0] mem_data_i,
  output logic done_o,
  output addr_gen_pkg::mode_t mode_o,
  output logic [2:0] len_o,
  output logic [15:0] ea_o,
  output logic [7:0] operand_o,
  output logic [15:0] target_o,
  output logic use_y_o,
  output logic [1:0] imask_o,
  output logic illegal_reset_o
);

  typedef enum logic [1:0] {S_OP, S_ARG, S_PTR, S_CALC} state_t;

  typedef struct packed {
    state_t st;
    addr_gen_pkg::mode_t mode;
    addr_gen_pkg::mode_t omode;
    logic pre_y;
    logic pre_ind;
    logic use_y;
    logic ouse_y;
    logic [7:0] op;
    logic [1:0] cnt;
    logic [2:0] len;
    logic [2:0] olen;
    logic [15:0] val;
    logic [15:0] maddr;
    logic mrd;
    logic [15:0] ea;
    logic [7:0] operand;
    logic [15:0] target;
    logic done;
    logic ill;
    logic [1:0] imask;
  } regs_t;

  regs_t s_q;
  regs_t s_d;
  logic [15:0] sum;
  logic [7:0] idx_sel;
  logic add_idx;
  logic [15:0] add_base;

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic addr_gen_pkg::mode_t base_mode(input logic [3:0] nib);
    case (nib)
      addr_gen_pkg::NIB_INH: base_mode = addr_gen_pkg::M_INH;
      addr_gen_pkg::NIB_IMM: base_mode = addr_gen_pkg::M_IMM;
      addr_gen_pkg::NIB_DIR_S: base_mode = addr_gen_pkg::M_DIR_S;
      addr_gen_pkg::NIB_DIR_L: base_mode = addr_gen_pkg::M_DIR_L;
      addr_gen_pkg::NIB_IDX0: base_mode = addr_gen_pkg::M_IDX0;
      addr_gen_pkg::NIB_IDX_S: base_mode = addr_gen_pkg::M_IDX_S;
      addr_gen_pkg::NIB_IDX_L: base_mode = addr_gen_pkg::M_IDX_L;
      default: base_mode = addr_gen_pkg::M_REL;
    endcase
  endfunction : base_mode

  function automatic addr_gen_pkg::mode_t to_indirect(
    input addr_gen_pkg::mode_t m);
    case (m)
      addr_gen_pkg::M_DIR_S: to_indirect = addr_gen_pkg::M_IND_S;
      addr_gen_pkg::M_DIR_L: to_indirect = addr_gen_pkg::M_IND_L;
      addr_gen_pkg::M_IDX_S: to_indirect = addr_gen_pkg::M_IIX_S;
      addr_gen_pkg::M_IDX_L: to_indirect = addr_gen_pkg::M_IIX_L;
      addr_gen_pkg::M_REL: to_indirect = addr_gen_pkg::M_REL_IND;
      default: to_indirect = m;
    endcase
  endfunction : to_indirect

  function automatic logic is_indirect(input addr_gen_pkg::mode_t m);
    is_indirect = m inside {addr_gen_pkg::M_IND_S, addr_gen_pkg::M_IND_L,
      addr_gen_pkg::M_IIX_S, addr_gen_pkg::M_IIX_L,
      addr_gen_pkg::M_REL_IND};
  endfunction : is_indirect

  function automatic logic is_illegal(input logic [7:0] b);
    logic [3:0] nib;
    nib = b[addr_gen_pkg::MODE_MSB:addr_gen_pkg::MODE_LSB];
    is_illegal = (nib > addr_gen_pkg::NIB_REL) ||
      (b[addr_gen_pkg::RMW_BIT] && (nib == addr_gen_pkg::NIB_DIR_L ||
      nib == addr_gen_pkg::NIB_IDX_L || nib == addr_gen_pkg::NIB_IMM));
  endfunction : is_illegal

  // ---------------------------------------------------------------
  // effective address adder
  // ---------------------------------------------------------------
  always_comb
  begin
    idx_sel = s_q.use_y ? index_y_i : index_x_i;
    add_idx = s_q.mode inside {addr_gen_pkg::M_IDX0, addr_gen_pkg::M_IDX_S,
      addr_gen_pkg::M_IDX_L, addr_gen_pkg::M_IIX_S, addr_gen_pkg::M_IIX_L};
    add_base = (s_q.mode == addr_gen_pkg::M_IDX0) ? 16'h0000 : s_q.val;
  end

  operand_adder operand_adder_inst (
    .base_i(add_base),
    .index_i(idx_sel),
    .add_index_i(add_idx),
    .sum_o(sum)
  );

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb
  begin
    addr_gen_pkg::mode_t bm;
    addr_gen_pkg::mode_t md;
    bm = addr_gen_pkg::M_INH;
    md = addr_gen_pkg::M_INH;
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.ill = 1'b0;
    case (s_q.st)
      S_OP:
      begin
        if (fetch_valid_i)
        begin
          if (fetch_byte_i == addr_gen_pkg::PRE_Y ||
              fetch_byte_i == addr_gen_pkg::PRE_IND)
          begin
            s_d.pre_y = (fetch_byte_i == addr_gen_pkg::PRE_Y);
            s_d.pre_ind = (fetch_byte_i == addr_gen_pkg::PRE_IND);
            s_d.len = addr_gen_pkg::LEN_ONE;
          end
          else if (is_illegal(fetch_byte_i))
          begin
            s_d.ill = 1'b1;
            s_d.pre_y = 1'b0;
            s_d.pre_ind = 1'b0;
            s_d.len = addr_gen_pkg::LEN_ZERO;
          end
          else
          begin
            bm = base_mode(fetch_byte_i[addr_gen_pkg::MODE_MSB:
              addr_gen_pkg::MODE_LSB]);
            md = s_q.pre_ind ? to_indirect(bm) : bm;
            s_d.op = fetch_byte_i;
            s_d.mode = md;
            s_d.cnt = addr_gen_pkg::extra_bytes(md);
            s_d.len = s_q.len + addr_gen_pkg::LEN_ONE;
            s_d.val = 16'h0000;
            s_d.use_y = s_q.pre_y && !s_q.pre_ind;
            if (fetch_byte_i == addr_gen_pkg::OP_SET_MASK)
              s_d.imask = addr_gen_pkg::MASK_HIGH;
            else if (fetch_byte_i == addr_gen_pkg::OP_CLR_MASK)
              s_d.imask = addr_gen_pkg::MASK_LOW;
            s_d.st = (addr_gen_pkg::extra_bytes(md) ==
              addr_gen_pkg::NO_BYTES) ? S_CALC : S_ARG;
          end
        end
      end
      S_ARG:
      begin
        if (fetch_valid_i)
        begin
          s_d.val = {s_q.val[7:0], fetch_byte_i};
          s_d.len = s_q.len + addr_gen_pkg::LEN_ONE;
          s_d.cnt = s_q.cnt - addr_gen_pkg::ONE_BYTE;
          if (s_q.cnt == addr_gen_pkg::ONE_BYTE)
          begin
            if (is_indirect(s_q.mode))
            begin
              s_d.maddr = {addr_gen_pkg::PAGE_ZERO, fetch_byte_i};
              s_d.mrd = 1'b1;
              s_d.val = 16'h0000;
              s_d.cnt = (s_q.mode inside {addr_gen_pkg::M_IND_L,
                addr_gen_pkg::M_IIX_L}) ? addr_gen_pkg::TWO_BYTES :
                addr_gen_pkg::ONE_BYTE;
              s_d.st = S_PTR;
            end
            else
              s_d.st = S_CALC;
          end
        end
      end
      S_PTR:
      begin
        if (mem_valid_i)
        begin
          s_d.val = {s_q.val[7:0], mem_data_i};
          s_d.maddr = s_q.maddr + addr_gen_pkg::ADDR_STEP;
          s_d.cnt = s_q.cnt - addr_gen_pkg::ONE_BYTE;
          if (s_q.cnt == addr_gen_pkg::ONE_BYTE)
          begin
            s_d.mrd = 1'b0;
            s_d.st = S_CALC;
          end
        end
      end
      S_CALC:
      begin
        s_d.ea = sum;
        s_d.operand = s_q.val[7:0];
        s_d.target = pc_i + {{8{s_q.val[7]}}, s_q.val[7:0]};
        s_d.omode = s_q.mode;
        s_d.olen = s_q.len;
        s_d.ouse_y = s_q.use_y;
        s_d.done = 1'b1;
        s_d.pre_y = 1'b0;
        s_d.pre_ind = 1'b0;
        s_d.len = addr_gen_pkg::LEN_ZERO;
        s_d.st = S_OP;
      end
      default: s_d.st = S_OP;
    endcase
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign fetch_ready_o = (s_q.st == S_OP) || (s_q.st == S_ARG);
  assign mem_rd_o = s_q.mrd;
  assign mem_addr_o = s_q.maddr;
  assign done_o = s_q.done;
  assign mode_o = s_q.omode;
  assign len_o = s_q.olen;
  assign ea_o = s_q.ea;
  assign operand_o = s_q.operand;
  assign target_o = s_q.target;
  assign use_y_o = s_q.ouse_y;
  assign imask_o = s_q.imask;
  assign illegal_reset_o = s_q.ill;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence op_taken_s;
    s_q.st == S_OP && fetch_valid_i &&
      fetch_byte_i != addr_gen_pkg::PRE_Y &&
      fetch_byte_i != addr_gen_pkg::PRE_IND;
  endsequence

  sequence ptr_last_s;
    s_q.st == S_PTR && mem_valid_i && s_q.cnt == addr_gen_pkg::ONE_BYTE;
  endsequence

  inherent_len_a: assert property (
    op_taken_s ##0 (!is_illegal(fetch_byte_i) && !s_q.pre_y &&
      !s_q.pre_ind && fetch_byte_i[7:4] == addr_gen_pkg::NIB_INH)
      |-> ##2 done_o && len_o == 3'h1)
    else $error("inherent length wrong");

  immediate_op_a: assert property (
    s_q.st == S_ARG && fetch_valid_i && s_q.mode == addr_gen_pkg::M_IMM
      |-> ##2 done_o && operand_o == $past(fetch_byte_i, 2))
    else $error("immediate operand wrong");

  short_page_a: assert property (
    done_o && mode_o inside {addr_gen_pkg::M_DIR_S, addr_gen_pkg::M_IND_S}
      |-> ea_o[15:8] == addr_gen_pkg::PAGE_ZERO)
    else $error("short address left page zero");

  noofs_index_a: assert property (
    done_o && mode_o == addr_gen_pkg::M_IDX0
      |-> ea_o == {8'h00, $past(idx_sel)} && len_o == $past(s_q.len))
    else $error("no-offset index address wrong");

  short_idx_range_a: assert property (
    done_o && mode_o inside {addr_gen_pkg::M_IDX_S, addr_gen_pkg::M_IIX_S}
      |-> ea_o <= addr_gen_pkg::SHORT_IDX_MAX)
    else $error("short indexed out of range");

  ptr_page_a: assert property (
    $rose(mem_rd_o) |-> mem_addr_o[15:8] == addr_gen_pkg::PAGE_ZERO &&
      is_indirect(s_q.mode))
    else $error("pointer read not in page zero");

  ptr_done_a: assert property (
    ptr_last_s |=> !mem_rd_o ##1 done_o && !mem_rd_o)
    else $error("pointer fetch did not complete");

  mask_level_a: assert property (
    op_taken_s ##0 fetch_byte_i == addr_gen_pkg::OP_SET_MASK
      |=> (imask_o == addr_gen_pkg::MASK_HIGH) [*2])
    else $error("mask not raised");

  illegal_code_a: assert property (
    op_taken_s ##0 is_illegal(fetch_byte_i)
      |=> illegal_reset_o && !done_o ##1 !illegal_reset_o)
    else $error("illegal code not reported");

  rmw_long_a: assert property (
    done_o |-> !(s_q.op[addr_gen_pkg::RMW_BIT] &&
      mode_o inside {addr_gen_pkg::M_DIR_L, addr_gen_pkg::M_IDX_L}))
    else $error("memory-modify in long form");

endmodule : operand_addr_gen

// ---- verilog/addr_gen_pkg.sv ----
/*
  Shared constants, opcode layout and addressing-mode type for the
  operand-address generator.
  Assumes the opcode layout below: mode in bits 7:4, memory-modify in bit 3.
*/
package addr_gen_pkg;

  // ---------------------------------------------------------------
  // prefix codes and special opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] PRE_Y = 8'h90;
  localparam logic [7:0] PRE_IND = 8'h92;
  localparam logic [7:0] OP_SET_MASK = 8'h0E;
  localparam logic [7:0] OP_CLR_MASK = 8'h0F;
  localparam logic [1:0] MASK_HIGH = 2'h3;
  localparam logic [1:0] MASK_LOW = 2'h0;

  // ---------------------------------------------------------------
  // opcode fields
  // ---------------------------------------------------------------
  localparam int MODE_MSB = 7;
  localparam int MODE_LSB = 4;
  localparam int RMW_BIT = 3;
  localparam logic [3:0] NIB_INH = 4'h0;
  localparam logic [3:0] NIB_IMM = 4'h1;
  localparam logic [3:0] NIB_DIR_S = 4'h2;
  localparam logic [3:0] NIB_DIR_L = 4'h3;
  localparam logic [3:0] NIB_IDX0 = 4'h4;
  localparam logic [3:0] NIB_IDX_S = 4'h5;
  localparam logic [3:0] NIB_IDX_L = 4'h6;
  localparam logic [3:0] NIB_REL = 4'h7;

  // ---------------------------------------------------------------
  // address and length constants
  // ---------------------------------------------------------------
  localparam logic [7:0] PAGE_ZERO = 8'h00;
  localparam logic [15:0] SHORT_IDX_MAX = 16'h01FE;
  localparam logic [15:0] ADDR_STEP = 16'h0001;
  localparam logic [1:0] NO_BYTES = 2'h0;
  localparam logic [1:0] ONE_BYTE = 2'h1;
  localparam logic [1:0] TWO_BYTES = 2'h2;
  localparam logic [2:0] LEN_ZERO = 3'h0;
  localparam logic [2:0] LEN_ONE = 3'h1;

  typedef enum logic [3:0] {
    M_INH, M_IMM, M_DIR_S, M_DIR_L, M_IDX0, M_IDX_S, M_IDX_L, M_REL,
    M_IND_S, M_IND_L, M_IIX_S, M_IIX_L, M_REL_IND
  } mode_t;

  // bytes that follow the opcode for a given mode
  function automatic logic [1:0] extra_bytes(input mode_t m);
    case (m)
      M_INH, M_IDX0: extra_bytes = NO_BYTES;
      M_DIR_L, M_IDX_L: extra_bytes = TWO_BYTES;
      default: extra_bytes = ONE_BYTE;
    endcase
  endfunction : extra_bytes

endpackage : addr_gen_pkg

// ---- verilog/operand_adder.sv ----
/*
  Unsigned 16-bit adder of a base address and an optional 8-bit index.
  Assumes purely combinational use by the address generator.
*/
`timescale 1ns/1ps
module operand_adder (
  input wire logic [15:0] base_i,
  input wire logic [7:0] index_i,
  input wire logic add_index_i,
  output logic [15:0] sum_o
);

  // ---------------------------------------------------------------
  // sum wraps inside the 16-bit space
  // ---------------------------------------------------------------
  always_comb
  begin
    sum_o = base_i + (add_index_i ? {8'h00, index_i} : 16'h0000);
  end

endmodule : operand_adder

// ---- bench/ptr_mem_model.sv ----
/*
  Data-memory model that answers the generator's pointer reads.
  Assumes requests are held until one valid pulse answers each byte;
  lat_i sets the number of idle cycles before each answer.
*/
`timescale 1ns/1ps
module ptr_mem_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] lat_i,
  input wire logic mem_rd_i,
  input wire logic [15:0] mem_addr_i,
  output logic mem_valid_o,
  output logic [7:0] mem_data_o
);
  // ---------------------------------------------------------------
  // answer path, driven on the falling edge
  // ---------------------------------------------------------------
  logic [3:0] wait_q;

  always @(negedge clk_i)
  begin
    if (!rst_n_i)
    begin
      mem_valid_o <= 1'b0;
      mem_data_o <= 8'h5A;
      wait_q <= 4'h0;
    end
    else if (mem_valid_o)
    begin
      // byte was taken: release and scramble the data lines
      mem_valid_o <= 1'b0;
      mem_data_o <= ~mem_data_o;
      wait_q <= 4'h0;
    end
    else if (mem_rd_i && wait_q == lat_i)
    begin
      mem_valid_o <= 1'b1;
      mem_data_o <= mem_addr_i[7:0] ^ 8'h3C;
    end
    else
    begin
      mem_data_o <= ~mem_data_o;
      wait_q <= mem_rd_i ? wait_q + 4'h1 : 4'h0;
    end
  end
endmodule : ptr_mem_model

// ---- bench/cpu_operand_address_generator_test.sv ----
/*
  Self-checking bench for the operand-address generator.
  Assumes the design package, the design and ptr_mem_model come first.
*/
`timescale 1ns/1ps
`define CHK(a, e) check_eq(32'(a), 32'(e))
module cpu_operand_address_generator_test;
  logic clk_i, rst_n_i, fetch_valid_i, fetch_ready_o, mem_rd_o, mem_valid_i;
  logic done_o, use_y_o, illegal_reset_o, saw_ill;
  logic [7:0] fetch_byte_i, index_x_i, index_y_i, mem_data_i, operand_o;
  logic [15:0] pc_i, mem_addr_o, ea_o, target_o;
  logic [2:0] len_o;
  logic [1:0] imask_o;
  logic [3:0] lat;
  addr_gen_pkg::mode_t mode_o;
  int mismatches = 0;
  int compares = 0;

  operand_addr_gen operand_addr_gen_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .fetch_valid_i(fetch_valid_i),
    .fetch_byte_i(fetch_byte_i), .fetch_ready_o(fetch_ready_o),
    .index_x_i(index_x_i), .index_y_i(index_y_i), .pc_i(pc_i),
    .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o), .mem_valid_i(mem_valid_i),
    .mem_data_i(mem_data_i), .done_o(done_o), .mode_o(mode_o),
    .len_o(len_o), .ea_o(ea_o), .operand_o(operand_o),
    .target_o(target_o), .use_y_o(use_y_o), .imask_o(imask_o),
    .illegal_reset_o(illegal_reset_o)
  );

  ptr_mem_model ptr_mem_model_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .lat_i(lat), .mem_rd_i(mem_rd_o),
    .mem_addr_i(mem_addr_o), .mem_valid_o(mem_valid_i),
    .mem_data_o(mem_data_i)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] pb(input logic [15:0] a);
    return a[7:0] ^ 8'h3C;
  endfunction : pb

  task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check_eq

  task automatic send(input logic [7:0] b);
    int n;
    n = 0;
    @(negedge clk_i);
    fetch_valid_i = 1'b1;
    fetch_byte_i = b;
    while (fetch_ready_o !== 1'b1 && n < 60)
    begin
      @(negedge clk_i);
      n++;
    end
    @(posedge clk_i);
  endtask : send

  // bytes are taken from the top of b, n of them
  task automatic run(input logic [31:0] b, input int n);
    int k;
    for (k = 0; k < n; k++)
      send(b[31 - 8 * k -: 8]);
    @(negedge clk_i);
    fetch_valid_i = 1'b0;
    fetch_byte_i = ~fetch_byte_i;
    k = 0;
    while (done_o !== 1'b1 && illegal_reset_o !== 1'b1 && k < 80)
    begin
      @(negedge clk_i);
      k++;
    end
    saw_ill = illegal_reset_o;
    `CHK(done_o | illegal_reset_o, 1'b1);
  endtask : run

  task automatic expect_dec(input addr_gen_pkg::mode_t m, input int l);
    `CHK(mode_o, m);
    `CHK(len_o, l[2:0]);
  endtask : expect_dec

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic test_inherent;
    `CHK(imask_o, 2'h0);
    run(32'h0E000000, 1);
    expect_dec(addr_gen_pkg::M_INH, 1);
    `CHK(imask_o, 2'h3);
    run(32'h0F000000, 1);
    expect_dec(addr_gen_pkg::M_INH, 1);
    `CHK(imask_o, 2'h0);
    $display("test_inherent done");
  endtask : test_inherent

  task automatic test_immediate;
    logic [7:0] bad [5];
    bad = '{8'h18, 8'h38, 8'h68, 8'h80, 8'hF5};
    run(32'h10A70000, 2);
    expect_dec(addr_gen_pkg::M_IMM, 2);
    `CHK(operand_o, 8'hA7);
    `CHK(use_y_o, 1'b0);
    run(32'h9010A700, 3);
    expect_dec(addr_gen_pkg::M_IMM, 3);
    `CHK(use_y_o, 1'b1);
    foreach (bad[i])
    begin
      run({bad[i], 24'h000000}, 1);
      `CHK(saw_ill, 1'b1);
    end
    $display("test_immediate done");
  endtask : test_immediate

  task automatic test_direct;
    run(32'h209C0000, 2);
    expect_dec(addr_gen_pkg::M_DIR_S, 2);
    `CHK(ea_o, 16'h009C);
    run(32'h28FF0000, 2);
    `CHK(ea_o, 16'h00FF);
    run(32'h30123400, 3);
    expect_dec(addr_gen_pkg::M_DIR_L, 3);
    `CHK(ea_o, 16'h1234);
    $display("test_direct done");
  endtask : test_direct

  task automatic test_indexed;
    run(32'h40000000, 1);
    expect_dec(addr_gen_pkg::M_IDX0, 1);
    `CHK(ea_o, 16'h0081);
    run(32'h90400000, 2);
    `CHK(ea_o, 16'h0042);
    index_x_i = 8'hFF;
    run(32'h50FF0000, 2);
    expect_dec(addr_gen_pkg::M_IDX_S, 2);
    `CHK(ea_o, 16'h01FE);
    index_x_i = 8'h81;
    run(32'h60FFF000, 3);
    expect_dec(addr_gen_pkg::M_IDX_L, 3);
    `CHK(ea_o, 16'h0071);
    $display("test_indexed done");
  endtask : test_indexed

  task automatic test_indirect;
    lat = 4'h0;
    run(32'h9220C300, 3);
    expect_dec(addr_gen_pkg::M_IND_S, 3);
    `CHK(ea_o, {8'h00, pb(16'h00C3)});
    run(32'h9230A000, 3);
    expect_dec(addr_gen_pkg::M_IND_L, 3);
    `CHK(ea_o, {pb(16'h00A0), pb(16'h00A1)});
    lat = 4'h5;
    send(8'h92);
    send(8'h20);
    send(8'hC3);
    @(negedge clk_i);
    `CHK({fetch_ready_o, mem_rd_o, mem_addr_o}, {2'h1, 16'h00C3});
    run(32'h00000000, 0);
    expect_dec(addr_gen_pkg::M_IND_S, 3);
    `CHK(ea_o, {8'h00, pb(16'h00C3)});
    index_x_i = 8'hFF;
    run(32'h9250C300, 3);
    expect_dec(addr_gen_pkg::M_IIX_S, 3);
    `CHK(ea_o, 16'h01FE);
    index_x_i = 8'h81;
    run(32'h9260A000, 3);
    expect_dec(addr_gen_pkg::M_IIX_L, 3);
    `CHK(ea_o, {pb(16'h00A0), pb(16'h00A1)} + 16'h0081);
    $display("test_indirect done");
  endtask : test_indirect

  task automatic test_relative;
    pc_i = 16'h1000;
    run(32'h70800000, 2);
    expect_dec(addr_gen_pkg::M_REL, 2);
    `CHK(target_o, 16'h0F80);
    run(32'h70050000, 2);
    `CHK(target_o, 16'h1005);
    run(32'h9270C300, 3);
    expect_dec(addr_gen_pkg::M_REL_IND, 3);
    `CHK(target_o, 16'h0FFF);
    $display("test_relative done");
  endtask : test_relative

  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish

  // ---------------------------------------------------------------
  // clock, watchdog and main sequence
  // ---------------------------------------------------------------
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  initial
  begin
    repeat (6000) @(posedge clk_i);
    mismatches++;
    tally_and_finish();
  end

  initial
  begin
    rst_n_i = 1'b0;
    fetch_valid_i = 1'b0;
    fetch_byte_i = 8'h00;
    index_x_i = 8'h81;
    index_y_i = 8'h42;
    pc_i = 16'h2000;
    lat = 4'h0;
    repeat (16) @(negedge clk_i);
    rst_n_i = 1'b1;
    test_inherent();
    test_immediate();
    test_direct();
    test_indexed();
    test_indirect();
    test_relative();
    tally_and_finish();
  end
endmodule : cpu_operand_address_generator_test
